// ### bench/stm_pin_partner.sv
`default_nettype none

module stm_pin_partner (
  input wire logic core_clk,
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic trig,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic float_q = 1'b0;
  initial trig = 1'b0;
  // released pin shows a level toggling every clock, not a held copy of the last driven one
  always @(posedge core_clk) float_q <= ~float_q;
  assign pin = pin_oe ? pin_o : float_q;
  // one rising trigger edge, dropped four clocks later
  task automatic trigger();
    trig <= 1'b1;
    fork
      begin
        repeat (4) @(posedge core_clk);
        trig <= 1'b0;
      end
    join_none
  endtask
endmodule

`default_nettype wire

// ### bench/stm_timer_asserts.sv
`default_nettype none

module stm_timer_chk
  import stm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire stm_axi_req_s axi_req,
  input wire stm_axi_rsp_s axi_rsp,
  input wire logic external_clock_pin,
  input wire logic timer_out_pin_a_o,
  input wire logic timer_out_pin_a_oe,
  input wire logic timer_out_pin_b_o,
  input wire logic timer_out_pin_b_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // shadow of landed control writes
  // ----------------------------------------
  logic [31:0] waddr_q;
  logic [31:0] raddr_q;
  logic [7:0] wdata_q;
  logic [7:0] ctrl0_q;
  stm_ctrl1_s ctrl1_q;
  logic [3:0] age_q;
  logic lvl;
  assign lvl = ctrl1_q.output_init_level ^ ctrl1_q.output_invert;

  always_ff @(posedge core_clk) begin
    if (axi_req.awvalid && axi_rsp.awready) waddr_q <= axi_req.awaddr;
    if (axi_req.wvalid && axi_rsp.wready) wdata_q <= axi_req.wdata[7:0];
    if (axi_req.arvalid && axi_rsp.arready) raddr_q <= axi_req.araddr;
  end

  // shadow lags the design by one edge, so age gates settled checks
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl0_q <= CTRL0_RST;
      ctrl1_q <= CTRL1_RST;
      age_q <= 4'h0;
    end else if ($rose(axi_rsp.bvalid) && waddr_q[31:3] == 29'h0) begin
      if (waddr_q[2]) ctrl1_q <= wdata_q;
      else ctrl0_q <= wdata_q;
      age_q <= 4'h0;
    end else if (age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_oe_by_mode: assert property (age_q > 4'h2 |->
    timer_out_pin_a_oe == (ctrl1_q.mode_select inside {STM_MODE_CMP, STM_MODE_PWM}))
    else $error("output enable wrong for mode");
  a_on_loads_init: assert property ($rose(ctrl0_q[CTRL0_ON_BIT]) &&
    ctrl1_q.mode_select == STM_MODE_CMP |-> ##[0:1] timer_out_pin_a_o == lvl)
    else $error("pin not loaded with initial level");
  a_hold_no_change: assert property (age_q > 4'h2 &&
    ctrl1_q.mode_select == STM_MODE_CMP && ctrl1_q.pin_function == STM_PF_HOLD
    |-> $stable(timer_out_pin_a_o))
    else $error("pin moved with hold action");
  a_pwm_forced: assert property (age_q > 4'h2 && ctrl0_q[CTRL0_ON_BIT] &&
    ctrl1_q.mode_select == STM_MODE_PWM && !ctrl1_q.pin_function[1]
    |-> timer_out_pin_a_o == (ctrl1_q.pin_function[0] ? lvl : !lvl))
    else $error("forced pwm level wrong");
  a_pulse_ext_start: assert property (age_q > 4'h2 && !ctrl0_q[CTRL0_ON_BIT] &&
    ctrl1_q.mode_select == STM_MODE_PWM && ctrl1_q.pin_function == STM_PF_TOGGLE &&
    $rose(external_clock_pin) |-> ##[3:6] timer_out_pin_a_o == lvl)
    else $error("external edge gave no pulse");
  a_upper_read_zero: assert property (axi_rsp.rvalid &&
    (raddr_q == ADDR_CNT_HI || raddr_q == ADDR_CMPA_HI) |-> axi_rsp.rdata[31:2] == 30'h0)
    else $error("unimplemented bits not zero");
  a_unmapped_err: assert property (axi_rsp.rvalid && raddr_q > ADDR_FLAGS
    |-> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_pin_copies: assert property (timer_out_pin_a_o == timer_out_pin_b_o &&
    timer_out_pin_a_oe == timer_out_pin_b_oe)
    else $error("pin copies differ");
endmodule

`default_nettype wire

// ### bench/stm_timer_tb.sv
`default_nettype none

module testbench
  import stm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  stm_axi_req_s axi_req = '{bready: 1'b1, rready: 1'b1, default: '0};
  stm_axi_rsp_s axi_rsp;
  logic ext_pin, pin_o, pin_oe, pin, b;
  logic [31:0] rd;
  int num_errors = 0;
  int compares = 0;
  int n;
  int pa[3] = '{32, 200, 200};
  int pw[3] = '{128, 128, 200};
  int pe[3] = '{32, 128, 128};

  always #50 core_clk = ~core_clk;

  stm_timer u_dut (.core_clk(core_clk), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .external_clock_pin(ext_pin), .timer_out_pin_a_o(pin_o), .timer_out_pin_a_oe(pin_oe),
    .timer_out_pin_b_o(), .timer_out_pin_b_oe());
  stm_pin_partner u_far (.core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe),
    .trig(ext_pin), .pin(pin));

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // bready stays high, so the answering edge ends the write
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1 && k < 50);
    rd = {30'h0, axi_rsp.bresp};
    if (k >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] exp, input string what);
    int k;
    k = 0;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1 && k < 50);
    rd = axi_rsp.rdata | {30'h0, axi_rsp.rresp};
    if (k >= 50) begin
      num_errors++;
      finish_test();
    end
    if (what != "") chk(what, exp, rd);
  endtask

  initial begin
    tick(5);
    srst <= 1'b0;
    tick(2);
    rc(ADDR_CNT_LO, 32'h0, "cnt_lo"); // zero after reset
    rc(ADDR_CNT_HI, 32'h0, "cnt_hi"); // zero after reset
    rc(ADDR_CMPA_LO, 32'h0, "cmpa_lo"); // zero after reset
    rc(ADDR_CMPA_HI, 32'h0, "cmpa_hi"); // zero after reset
    rc(32'h1C, 32'h2, "unmapped");
    wr(32'h1C, 32'h1);
    chk("bresp_unmapped", {30'h0, RESP_SLVERR}, rd);
    wr(ADDR_CMPA_LO, 32'hA5);
    wr(ADDR_CMPA_HI, 32'hFFFFFFFF);
    wr(ADDR_CNT_LO, 32'h55);
    chk("bresp_ro", {30'h0, RESP_OKAY}, rd); // write accepted, ignored
    rc(ADDR_CMPA_LO, 32'hA5, "cmpa_lo_rw"); // low byte
    rc(ADDR_CMPA_HI, 32'h3, "cmpa_hi_rw"); // two bits kept
    rc(ADDR_CNT_LO, 32'h0, "cnt_ro"); // write ignored
    $display("done registers");
    wr(ADDR_CMPA_HI, 32'h0);
    wr(ADDR_CMPA_LO, 32'h64); // kept nonzero
    wr(ADDR_CTRL1, 32'h0);
    wr(ADDR_CTRL0, 32'h9);
    tick(300);
    rc(ADDR_CNT_HI, 32'h0, "cnt_wrap"); // clears at 128
    rc(ADDR_FLAGS, 32'h3, "flags_p"); // both flags
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_FLAGS, 32'h3);
    wr(ADDR_CMPA_HI, 32'h1);
    wr(ADDR_CMPA_LO, 32'h2C);
    wr(ADDR_CTRL1, 32'h1);
    wr(ADDR_CTRL0, 32'h9);
    tick(700);
    rc(ADDR_FLAGS, 32'h1, "flags_a"); // no period flag
    $display("done clearing");
    wr(ADDR_CMPA_HI, 32'h0);
    wr(ADDR_CMPA_LO, 32'h14);
    for (int pf = 0; pf < 4; pf++) begin
      wr(ADDR_CTRL0, 32'h0);
      wr(ADDR_CTRL1, {26'h0, pf[1:0], pf == 1, 3'b001});
      wr(ADDR_CTRL0, 32'h8);
      tick(45);
      b = pin;
      tick(20);
      chk("pin_action", (pf == 3) ? !b : pf == 2, pin); // match action
    end
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CTRL1, 32'hF1);
    wr(ADDR_FLAGS, 32'h3);
    wr(ADDR_CTRL0, 32'h8);
    tick(50);
    chk("oe_timer", 32'h0, pin_oe); // pin left free
    rc(ADDR_FLAGS, 32'h1, "flags_tmr"); // flags as compare
    wr(ADDR_CMPA_HI, 32'h3);
    wr(ADDR_CMPA_LO, 32'hE8);
    tick(100);
    wr(ADDR_CTRL0, 32'h88);
    rc(ADDR_CNT_LO, 32'h0, "");
    n = rd;
    tick(10);
    rc(ADDR_CNT_LO, n, "paused"); // frozen
    wr(ADDR_CTRL0, 32'h8);
    rc(ADDR_CNT_LO, 32'h0, "");
    chk("resumed", 32'h1, rd > n); // counts on
    wr(ADDR_CTRL0, 32'h0);
    rc(ADDR_CNT_LO, 32'h0, "");
    n = rd;
    tick(10);
    rc(ADDR_CNT_LO, n, "held"); // off holds
    wr(ADDR_CTRL0, 32'h8);
    rc(ADDR_CNT_LO, 32'h0, "");
    chk("restart", 32'h1, rd < 16); // rising on clears
    $display("done timer");
    wr(ADDR_CMPA_HI, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL0, 32'h0);
      wr(ADDR_CMPA_LO, pa[i]);
      wr(ADDR_CTRL1, {24'h0, 6'b101010, i == 2, 1'b1});
      wr(ADDR_CTRL0, 32'h9);
      tick(256);
      n = 0;
      repeat (pw[i]) begin
        tick(1);
        n += (pin === 1'b1);
      end
      chk("pwm_duty", pe[i], n); // period and duty
    end
    wr(ADDR_FLAGS, 32'h3);
    tick(300);
    rc(ADDR_FLAGS, 32'h3, "flags_pwm"); // two flags
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CTRL1, 32'h9B);
    wr(ADDR_CTRL0, 32'h9);
    wr(ADDR_FLAGS, 32'h3);
    tick(300);
    chk("forced", 32'h1, pin); // fixed active level
    rc(ADDR_FLAGS, 32'h3, "flags_forced"); // still counting
    $display("done pwm");
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CMPA_LO, 32'h28);
    wr(ADDR_CTRL1, 32'hB8);
    wr(ADDR_FLAGS, 32'h3);
    tick(4);
    u_far.trigger(); // external start
    n = 0;
    while (pin !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
    n = 0;
    while (pin === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("pulse_len", 32'h1, n > 38 && n < 42); // width from compare A
    rc(ADDR_CTRL0, 32'h0, "");
    chk("on_cleared", 32'h0, rd[CTRL0_ON_BIT]); // hardware clears on
    rc(ADDR_FLAGS, 32'h0, "");
    chk("flag_pulse", 32'h1, rd[FLAGS_A_BIT]); // compare A flag
    rc(ADDR_CNT_LO, 32'h0, "");
    chk("pulse_cnt", 32'h1, rd != 0); // match does not clear counter
    wr(ADDR_CTRL0, 32'h8);
    tick(1);
    chk("fw_start", 32'h1, pin); // leading edge
    wr(ADDR_CTRL0, 32'h0);
    tick(1);
    chk("fw_stop", 32'h0, pin); // trailing edge
    $display("done pulse");
    finish_test();
  end
endmodule

bind stm_timer stm_timer_chk u_chk (.core_clk(core_clk), .srst(srst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .external_clock_pin(external_clock_pin),
  .timer_out_pin_a_o(timer_out_pin_a_o), .timer_out_pin_a_oe(timer_out_pin_a_oe),
  .timer_out_pin_b_o(timer_out_pin_b_o), .timer_out_pin_b_oe(timer_out_pin_b_oe));

`default_nettype wire

// ### hdl/stm_pkg.sv
`default_nettype none

package stm_pkg;

  // ----------------------------------------------------------------
  // counter geometry
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 10;
  localparam logic [10:0] PERIOD_FULL = 11'h400;
  localparam int unsigned PERIOD_STEP_LSB = 7;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_CTRL0 = 32'h0000_0000;
  localparam logic [31:0] ADDR_CTRL1 = 32'h0000_0004;
  localparam logic [31:0] ADDR_CNT_LO = 32'h0000_0008;
  localparam logic [31:0] ADDR_CNT_HI = 32'h0000_000C;
  localparam logic [31:0] ADDR_CMPA_LO = 32'h0000_0010;
  localparam logic [31:0] ADDR_CMPA_HI = 32'h0000_0014;
  localparam logic [31:0] ADDR_FLAGS = 32'h0000_0018;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL0_PAUSE_BIT = 7;
  localparam int unsigned CTRL0_ON_BIT = 3;
  localparam int unsigned CTRL0_PCODE_LSB = 0;
  localparam int unsigned FLAGS_A_BIT = 0;
  localparam int unsigned FLAGS_P_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] CMPA_RST = 10'h000;
  localparam logic [9:0] CNT_RST = 10'h000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'b00,
    STM_MODE_CAP = 2'b01,
    STM_MODE_PWM = 2'b10,
    STM_MODE_TMR = 2'b11
  } stm_mode_e;

  // compare mode meaning; in pwm mode: 00 inactive, 01 active,
  // 10 waveform, 11 single pulse
  typedef enum logic [1:0] {
    STM_PF_HOLD = 2'b00,
    STM_PF_LOW = 2'b01,
    STM_PF_HIGH = 2'b10,
    STM_PF_TOGGLE = 2'b11
  } stm_pinfn_e;

  // bit layout of timer_control_one, msb first
  typedef struct packed {
    stm_mode_e mode_select;
    stm_pinfn_e pin_function;
    logic output_init_level;
    logic output_invert;
    logic duty_period_swap;
    logic clear_select;
  } stm_ctrl1_s;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } stm_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } stm_axi_rsp_s;

endpackage

`default_nettype wire

// ### hdl/stm_sync.sv
`default_nettype none

module stm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### hdl/stm_timer.sv
`default_nettype none

module stm_timer
  import stm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire stm_axi_req_s axi_req,
  output stm_axi_rsp_s axi_rsp,
  input wire logic external_clock_pin,
  output logic timer_out_pin_a_o,
  output logic timer_out_pin_a_oe,
  output logic timer_out_pin_b_o,
  output logic timer_out_pin_b_oe
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic counter_pause_q;
  logic [2:0] period_code_q;
  logic timer_on_q;
  logic timer_on_prev_q;
  stm_ctrl1_s ctrl1_q;
  logic [9:0] compare_a_value_q;
  logic [9:0] counter_q;
  logic compare_a_flag_q;
  logic period_match_flag_q;
  logic cmp_level_q;
  logic ext_prev_q;
  logic ext_sync;

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [31:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic wr_lane0;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_cmpa_lo;
  logic wr_cmpa_hi;
  logic wr_flags;
  logic wr_mapped;
  logic [31:0] rd_data;
  logic rd_mapped;

  // ----------------------------------------------------------------
  // decoded operation
  // ----------------------------------------------------------------
  logic on_rise;
  logic run;
  logic [10:0] count_next;
  logic [10:0] period_dur;
  logic amatch;
  logic pmatch;
  logic is_cmp_like;
  logic is_pwm;
  logic is_single;
  logic clear_cnt;
  logic set_aflag;
  logic set_pflag;
  logic trig_rise;
  logic [10:0] duty;
  logic wave;
  logic pin_level;

  stm_sync #(
    .WIDTH(1)
  ) u_ext_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(external_clock_pin),
    .sync_out(ext_sync)
  );

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  // address and data are taken in either order; the write lands once
  // both are held and no response is waiting
  assign wr_fire = aw_held_q & w_held_q & ~axi_rsp.bvalid;
  assign wr_lane0 = wr_fire & wstrb_q[0];

  always_comb begin
    wr_ctrl0 = 1'b0;
    wr_ctrl1 = 1'b0;
    wr_cmpa_lo = 1'b0;
    wr_cmpa_hi = 1'b0;
    wr_flags = 1'b0;
    wr_mapped = 1'b1;
    if (waddr_q == ADDR_CTRL0) begin
      wr_ctrl0 = wr_lane0;
    end else if (waddr_q == ADDR_CTRL1) begin
      wr_ctrl1 = wr_lane0;
    end else if (waddr_q == ADDR_CMPA_LO) begin
      wr_cmpa_lo = wr_lane0;
    end else if (waddr_q == ADDR_CMPA_HI) begin
      wr_cmpa_hi = wr_lane0;
    end else if (waddr_q == ADDR_FLAGS) begin
      wr_flags = wr_lane0;
    end else if (waddr_q == ADDR_CNT_LO || waddr_q == ADDR_CNT_HI) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_held_q <= 1'b0;
      waddr_q <= '0;
      axi_rsp.awready <= 1'b0;
    end else if (axi_req.awvalid && axi_rsp.awready) begin
      aw_held_q <= 1'b1;
      waddr_q <= axi_req.awaddr;
      axi_rsp.awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      axi_rsp.awready <= 1'b1;
    end else begin
      axi_rsp.awready <= ~aw_held_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      axi_rsp.wready <= 1'b0;
    end else if (axi_req.wvalid && axi_rsp.wready) begin
      w_held_q <= 1'b1;
      wdata_q <= axi_req.wdata;
      wstrb_q <= axi_req.wstrb;
      axi_rsp.wready <= 1'b0;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
      axi_rsp.wready <= 1'b1;
    end else begin
      axi_rsp.wready <= ~w_held_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      axi_rsp.bvalid <= 1'b0;
      axi_rsp.bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      axi_rsp.bvalid <= 1'b1;
      axi_rsp.bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req.bready) begin
      axi_rsp.bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    rd_mapped = 1'b1;
    if (axi_req.araddr == ADDR_CTRL0) begin
      rd_data[CTRL0_PAUSE_BIT] = counter_pause_q;
      rd_data[CTRL0_ON_BIT] = timer_on_q;
      rd_data[CTRL0_PCODE_LSB +: 3] = period_code_q;
    end else if (axi_req.araddr == ADDR_CTRL1) begin
      rd_data[7:0] = ctrl1_q;
    end else if (axi_req.araddr == ADDR_CNT_LO) begin
      rd_data[7:0] = counter_q[7:0];
    end else if (axi_req.araddr == ADDR_CNT_HI) begin
      rd_data[1:0] = counter_q[9:8];
    end else if (axi_req.araddr == ADDR_CMPA_LO) begin
      rd_data[7:0] = compare_a_value_q[7:0];
    end else if (axi_req.araddr == ADDR_CMPA_HI) begin
      rd_data[1:0] = compare_a_value_q[9:8];
    end else if (axi_req.araddr == ADDR_FLAGS) begin
      rd_data[FLAGS_A_BIT] = compare_a_flag_q;
      rd_data[FLAGS_P_BIT] = period_match_flag_q;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid <= 1'b0;
      axi_rsp.rdata <= '0;
      axi_rsp.rresp <= RESP_OKAY;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid <= 1'b1;
      axi_rsp.rdata <= rd_data;
      axi_rsp.rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_rsp.rvalid && axi_req.rready) begin
      axi_rsp.rvalid <= 1'b0;
      axi_rsp.arready <= 1'b1;
    end else begin
      axi_rsp.arready <= ~axi_rsp.rvalid;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // mode and pin function should only change while the timer is off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      counter_pause_q <= CTRL0_RST[CTRL0_PAUSE_BIT];
      period_code_q <= CTRL0_RST[CTRL0_PCODE_LSB +: 3];
      ctrl1_q <= CTRL1_RST;
    end else begin
      if (wr_ctrl0) begin
        counter_pause_q <= wdata_q[CTRL0_PAUSE_BIT];
        period_code_q <= wdata_q[CTRL0_PCODE_LSB +: 3];
      end
      if (wr_ctrl1) begin
        ctrl1_q <= wdata_q[7:0];
      end
    end
  end

  // compare-A written one byte at a time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_a_value_q <= CMPA_RST;
    end else if (wr_cmpa_lo) begin
      compare_a_value_q[7:0] <= wdata_q[7:0];
    end else if (wr_cmpa_hi) begin
      compare_a_value_q[9:8] <= wdata_q[1:0];
    end
  end

  // ----------------------------------------------------------------
  // mode decode and comparators
  // ----------------------------------------------------------------
  // timer mode shares compare-mode counting and flags
  assign is_cmp_like = (ctrl1_q.mode_select == STM_MODE_CMP) ||
                       (ctrl1_q.mode_select == STM_MODE_TMR);
  // pwm also covers forced-level pin functions
  assign is_pwm = (ctrl1_q.mode_select == STM_MODE_PWM) &&
                  (ctrl1_q.pin_function != STM_PF_TOGGLE);
  // single pulse selected by pin function 11
  assign is_single = (ctrl1_q.mode_select == STM_MODE_PWM) &&
                     (ctrl1_q.pin_function == STM_PF_TOGGLE);

  assign on_rise = timer_on_q & ~timer_on_prev_q;
  assign run = timer_on_q & ~counter_pause_q & ~on_rise;
  assign count_next = {1'b0, counter_q} + 11'h001;

  // period code steps are 128 clocks, code zero is a full wrap
  assign period_dur = (period_code_q == 3'h0) ? PERIOD_FULL :
                      {1'b0, period_code_q, {PERIOD_STEP_LSB{1'b0}}};

  assign amatch = run && (count_next == {1'b0, compare_a_value_q});
  assign pmatch = run && (count_next == period_dur);

  // external edge only arms the single pulse while the timer is off
  assign trig_rise = is_single & ext_sync & ~ext_prev_q & ~timer_on_q;

  always_comb begin
    clear_cnt = 1'b0;
    set_aflag = 1'b0;
    set_pflag = 1'b0;
    if (is_cmp_like) begin
      if (ctrl1_q.clear_select) begin
        clear_cnt = amatch;
        set_aflag = amatch;
      end else begin
        // period match or overflow clears, both flags
        clear_cnt = pmatch;
        set_aflag = amatch;
        set_pflag = pmatch;
      end
    end else if (is_pwm) begin
      clear_cnt = ctrl1_q.duty_period_swap ? amatch : pmatch;
      set_aflag = amatch;
      set_pflag = pmatch;
    end else if (is_single) begin
      // compare-A match raises the interrupt flag
      set_aflag = amatch;
    end else begin
      clear_cnt = pmatch;
    end
  end

  // ----------------------------------------------------------------
  // on bit and counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer_on_q <= CTRL0_RST[CTRL0_ON_BIT];
    // compare-A match ends the pulse by clearing the on bit
    end else if (is_single && amatch) begin
      timer_on_q <= 1'b0;
    // external edge sets the on bit
    end else if (trig_rise) begin
      timer_on_q <= 1'b1;
    end else if (wr_ctrl0) begin
      timer_on_q <= wdata_q[CTRL0_ON_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer_on_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      timer_on_prev_q <= timer_on_q;
      ext_prev_q <= ext_sync;
    end
  end

  // clear on rise, hold while off
  // single pulse never clears on a match
  always_ff @(posedge core_clk) begin
    if (srst) begin
      counter_q <= CNT_RST;
    end else if (on_rise) begin
      counter_q <= CNT_RST;
    end else if (clear_cnt) begin
      counter_q <= CNT_RST;
    end else if (run) begin
      counter_q <= count_next[9:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt request flags, write one to clear
  // ----------------------------------------------------------------
  // a match in the clearing cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_a_flag_q <= 1'b0;
      period_match_flag_q <= 1'b0;
    end else begin
      compare_a_flag_q <= set_aflag |
        (compare_a_flag_q & ~(wr_flags & wdata_q[FLAGS_A_BIT]));
      period_match_flag_q <= set_pflag |
        (period_match_flag_q & ~(wr_flags & wdata_q[FLAGS_P_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // compare-mode pin level
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmp_level_q <= 1'b0;
    // initial level loaded on rising on bit
    end else if (on_rise) begin
      cmp_level_q <= ctrl1_q.output_init_level;
    // only compare-A matches move the pin
    end else if (is_cmp_like && set_aflag) begin
      case (ctrl1_q.pin_function)
        STM_PF_HOLD: cmp_level_q <= cmp_level_q;
        STM_PF_LOW: cmp_level_q <= 1'b0;
        STM_PF_HIGH: cmp_level_q <= 1'b1;
        default: cmp_level_q <= ~cmp_level_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // waveform and pin drive
  // ----------------------------------------------------------------
  // swap zero: duty is compare-A
  // swap one: duty is the period code span
  assign duty = ctrl1_q.duty_period_swap ? period_dur : {1'b0, compare_a_value_q};

  always_comb begin
    wave = 1'b0;
    if (is_pwm) begin
      // pin forcing does not touch the counter
      case (ctrl1_q.pin_function)
        STM_PF_HOLD: wave = 1'b0;
        STM_PF_LOW: wave = 1'b1;
        // counter never reaches a duty at or above period
        default: wave = timer_on_q && ({1'b0, counter_q} < duty);
      endcase
    end else if (is_single) begin
      // pulse active while the on bit is high
      wave = timer_on_q;
    end
  end

  // active level from init bit, then final inversion
  always_comb begin
    if (ctrl1_q.mode_select == STM_MODE_CMP) begin
      pin_level = cmp_level_q ^ ctrl1_q.output_invert;
    end else begin
      pin_level = (wave ? ctrl1_q.output_init_level : ~ctrl1_q.output_init_level) ^
                  ctrl1_q.output_invert;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer_out_pin_a_o <= 1'b0;
      timer_out_pin_b_o <= 1'b0;
      timer_out_pin_a_oe <= 1'b0;
      timer_out_pin_b_oe <= 1'b0;
    end else begin
      timer_out_pin_a_o <= pin_level;
      timer_out_pin_b_o <= pin_level;
      // timer mode leaves the pin undriven
      timer_out_pin_a_oe <= (ctrl1_q.mode_select == STM_MODE_CMP) ||
                            (ctrl1_q.mode_select == STM_MODE_PWM);
      timer_out_pin_b_oe <= (ctrl1_q.mode_select == STM_MODE_CMP) ||
                            (ctrl1_q.mode_select == STM_MODE_PWM);
    end
  end

endmodule

`default_nettype wire
